// ---- logic/cpid_top.sv ----
/*
 Command pulse input decoder with deviation counter, smoothing filter,
 torque limit request handling and AXI4-Lite registers.
 Assumes pins are asynchronous; servo, alarm, encoder and current come
 from logic on the same clock.
*/
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cpid_params.svh"
module cpid_top #(
    parameter int DEV_W         = 24,   // Deviation counter width
    parameter bit COUNT_DIR_RST = 1'b0  // Per-unit count direction
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        forward_pulse_i,     // First pulse pin
    input  wire logic        reverse_sign_i,      // Second pulse pin
    input  wire logic        torque_limit_request_i,
    input  wire logic        deviation_clear_request_i,
    input  wire logic        servo_on_i,
    input  wire logic        alarm_i,
    input  wire logic        home_return_i,
    input  wire logic        forced_stop_i,
    input  wire logic        enc_step_i,          // Feedback count
    input  wire logic        enc_fwd_i,           // Feedback direction
    input  wire logic [6:0]  torque_current_i,    // Percent of rated
    output logic             cmd_step_o,          // Smoothed command
    output logic             cmd_fwd_o,
    output logic             limit_en_o,
    output logic [6:0]       current_limit_o,
    output logic             torque_limited_flag_o,
    output logic             in_position_flag_o,
    output logic             dev_error_o,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    initial begin
        if (DEV_W < 8 || DEV_W > 31) $error("DEV_W out of range");
    end

    localparam logic [31:0] UNIT_CYC = 32'(`CPID_UNIT_CYC);

    // -----------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------
    logic [3:0] pin_w;   // clr, tl, second, first
    logic [3:0] lvl_w;   // Settled levels
    logic [3:0] nlv_w;   // Next settled levels
    assign pin_w = {deviation_clear_request_i, torque_limit_request_i,
                    reverse_sign_i, forward_pulse_i};

    // Three flops; a change counts when the last two agree
    genvar g;
    for (g = 0; g < 4; g++) begin : g_sync
        logic [2:0] sh_reg, sh_next;
        logic       lv_reg, lv_next;
        always_comb begin
            sh_next = {sh_reg[1:0], pin_w[g]};
            lv_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[1] : lv_reg;  // see RULE21
        end
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                sh_reg <= 3'h0;
                lv_reg <= 1'b0;
            end else begin
                sh_reg <= sh_next;
                lv_reg <= lv_next;
            end
        end
        assign lvl_w[g] = lv_reg;
        assign nlv_w[g] = lv_next;
    end

    // -----------------------------------------------------------
    // Register file state
    // -----------------------------------------------------------
    cpid_pkg::cpid_cfg_type cfg_reg, cfg_next;
    logic [10:0]      smooth_reg, smooth_next;  // Units of 0.1 ms
    logic [6:0]       tlim_reg, tlim_next;
    logic [DEV_W-1:0] inpw_reg, inpw_next;
    logic [DEV_W-1:0] errth_reg, errth_next;
    logic             err_w1c;                  // Error clear strobe
    logic             clear_now;

    // -----------------------------------------------------------
    // Pulse decode
    // -----------------------------------------------------------
    logic a_n, a_c, b_n, b_c, ch_a, ch_b, a_rise, b_rise;
    logic dec_step, dec_up, raw_up;
    always_comb begin
        a_n    = nlv_w[0] ^ cfg_reg.polarity;   // see RULE5
        a_c    = lvl_w[0] ^ cfg_reg.polarity;
        b_n    = nlv_w[1] ^ cfg_reg.polarity;
        b_c    = lvl_w[1] ^ cfg_reg.polarity;
        ch_a   = a_n ^ a_c;
        ch_b   = b_n ^ b_c;
        a_rise = a_n & ~a_c;
        b_rise = b_n & ~b_c;
        dec_step = 1'b0;
        raw_up   = 1'b0;
        case (cfg_reg.pulse_format)
            `CPID_FMT_PAIR: begin
                // Simultaneous edges cancel, so nothing moves
                dec_step = a_rise ^ b_rise;     // see RULE2
                raw_up   = a_rise;
            end
            `CPID_FMT_SIGN: begin
                dec_step = a_rise;              // see RULE3
                raw_up   = b_n;
            end
            `CPID_FMT_QUAD: begin
                // Both phases moving at once is illegal and is dropped
                dec_step = ch_a ^ ch_b;         // see RULE4
                raw_up   = ch_a ? (a_n ^ b_c) : ~(a_c ^ b_n);
            end
            default: begin
                dec_step = 1'b0;
            end
        endcase
        dec_up = raw_up ^ cfg_reg.count_dir;    // see RULE6
    end

    // -----------------------------------------------------------
    // First-order smoothing
    // -----------------------------------------------------------
    // Release rate is pending/tau steps per cycle: an exponential decay
    // that keeps every pulse, settling in roughly three tau.
    logic signed [DEV_W-1:0] pend_reg, pend_next, pend_sum;
    logic [31:0] racc_reg, racc_next, racc_sum, tau_cyc, mag;
    logic        rel, cstep_next, cfwd_next;
    always_comb begin
        tau_cyc  = 32'(smooth_reg) * UNIT_CYC;
        pend_sum = pend_reg + (dec_step ? (dec_up ? DEV_W'(1) : -DEV_W'(1))
                                        : DEV_W'(0));
        mag      = 32'(pend_sum[DEV_W-1] ? -pend_sum : pend_sum);
        racc_sum = racc_reg + mag;
        rel       = 1'b0;
        racc_next = 32'h0;
        if (tau_cyc == 32'h0) begin
            rel = (mag != 32'h0);               // see RULE7
        end else if (mag != 32'h0) begin
            rel       = (racc_sum >= tau_cyc);  // see RULE8
            racc_next = rel ? racc_sum - tau_cyc : racc_sum;
        end
        cstep_next = rel;
        cfwd_next  = ~pend_sum[DEV_W-1];
        pend_next  = pend_sum;
        if (rel) begin
            pend_next = cfwd_next ? pend_sum - DEV_W'(1) : pend_sum + DEV_W'(1);
        end
        if (clear_now) begin
            pend_next  = '0;
            racc_next  = 32'h0;
            cstep_next = 1'b0;
        end
    end

    // -----------------------------------------------------------
    // Deviation counter and flags
    // -----------------------------------------------------------
    logic signed [DEV_W-1:0] dev_reg, dev_next;
    logic [DEV_W-1:0] absdev;
    logic tl_active, clr_rise;
    logic tlf_next, inp_next, err_reg, err_next, len_next;
    logic [6:0] clim_next;
    always_comb begin
        clr_rise  = nlv_w[3] & ~lvl_w[3];       // see RULE17
        clear_now = (clr_rise & ~cfg_reg.clr_in_dis)            // see RULE14
                  | (cfg_reg.stop_clear & (~servo_on_i | alarm_i)); // see RULE12
        tl_active = lvl_w[2] & ~cfg_reg.tl_in_dis               // see RULE15
                  & ~home_return_i & ~forced_stop_i & servo_on_i; // see RULE18
        dev_next = dev_reg;
        if (cmd_step_o) begin
            dev_next = cmd_fwd_o ? dev_next + DEV_W'(1) : dev_next - DEV_W'(1);
        end
        if (enc_step_i) begin
            dev_next = enc_fwd_i ? dev_next - DEV_W'(1) : dev_next + DEV_W'(1); // see RULE20
        end
        if (clear_now) begin
            dev_next = '0;
        end
        absdev    = dev_reg[DEV_W-1] ? -dev_reg : dev_reg;
        len_next  = tl_active;
        clim_next = tl_active ? tlim_reg : `CPID_NO_LIMIT;      // see RULE10
        // A clear drops it for every cycle that clear_now is high
        tlf_next  = tl_active & (torque_current_i >= tlim_reg)  // see RULE11
                  & ~clear_now;                                 // see RULE17
        inp_next  = servo_on_i & (absdev <= inpw_reg);          // see RULE16
        // Setting wins over a clear in the same cycle
        err_next  = (err_reg & ~err_w1c)
                  | (cfg_reg.err_mon & tl_active & (absdev > errth_reg)); // see RULE13
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_reg              <= '0;
            racc_reg              <= 32'h0;
            cmd_step_o            <= 1'b0;
            cmd_fwd_o             <= 1'b0;
            dev_reg               <= '0;
            limit_en_o            <= 1'b0;
            current_limit_o       <= `CPID_NO_LIMIT;
            torque_limited_flag_o <= 1'b0;
            in_position_flag_o    <= 1'b0;
            err_reg               <= 1'b0;
        end else begin
            pend_reg              <= pend_next;
            racc_reg              <= racc_next;
            cmd_step_o            <= cstep_next;
            cmd_fwd_o             <= cfwd_next;
            dev_reg               <= dev_next;
            limit_en_o            <= len_next;
            current_limit_o       <= clim_next;
            torque_limited_flag_o <= tlf_next;
            in_position_flag_o    <= inp_next;
            err_reg               <= err_next;
        end
    end
    assign dev_error_o = err_reg;

    // -----------------------------------------------------------
    // AXI4-Lite slave
    // -----------------------------------------------------------
    logic        awh_reg, awh_next, wh_reg, wh_next, bv_next, rv_next;
    logic [7:0]  awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next, wm, rd_next;
    logic [3:0]  ws_reg, ws_next;
    logic [1:0]  br_next, rr_next;
    cpid_pkg::cpid_stat_type stat;

    // Byte-lane merge of write data over an old value
    function automatic logic [31:0] merge(input logic [31:0] old_v);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (ws_reg[i]) r[i*8 +: 8] = wd_reg[i*8 +: 8];
        end
        return r;
    endfunction : merge

    assign s_axi_awready = ~awh_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~wh_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign stat = '{limit_active: limit_en_o, dev_error: err_reg,
                    torque_limited: torque_limited_flag_o,
                    in_position: in_position_flag_o};

    always_comb begin
        awh_next = awh_reg | s_axi_awvalid & s_axi_awready;
        awa_next = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awa_reg;
        wh_next  = wh_reg | s_axi_wvalid & s_axi_wready;
        wd_next  = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd_reg;
        ws_next  = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : ws_reg;
        bv_next  = s_axi_bvalid & ~s_axi_bready;
        br_next  = s_axi_bresp;
        cfg_next = cfg_reg;
        smooth_next = smooth_reg;
        tlim_next   = tlim_reg;
        inpw_next   = inpw_reg;
        errth_next  = errth_reg;
        err_w1c     = 1'b0;
        wm          = 32'h0;
        // Write once address and data are both held
        if (awh_reg && wh_reg) begin
            awh_next = 1'b0;
            wh_next  = 1'b0;
            bv_next  = 1'b1;
            br_next  = 2'h0;
            case (awa_reg)
                `CPID_ADDR_CTRL: begin
                    wm = merge(32'(cfg_reg));
                    // Illegal format leaves the control word unchanged
                    if (wm[1:0] <= `CPID_FMT_MAX) cfg_next = wm[7:0]; // see RULE1
                end
                `CPID_ADDR_SMOOTH: begin
                    wm = merge(32'(smooth_reg));
                    if (wm <= 32'(`CPID_SMOOTH_MAX)) smooth_next = wm[10:0];
                end
                `CPID_ADDR_TLIM: begin
                    wm = merge(32'(tlim_reg));
                    if (wm <= 32'(`CPID_TLIM_MAX)) tlim_next = wm[6:0]; // see RULE9
                end
                `CPID_ADDR_INPW: begin
                    wm = merge(32'(inpw_reg));
                    inpw_next = wm[DEV_W-1:0];
                end
                `CPID_ADDR_ERRTH: begin
                    wm = merge(32'(errth_reg));
                    errth_next = wm[DEV_W-1:0];
                end
                `CPID_ADDR_STATUS: begin
                    err_w1c = ws_reg[0] & wd_reg[`CPID_ERR_BIT];
                end
                default: begin
                    br_next = 2'h2;               // Unmapped: SLVERR
                end
            endcase
        end
        rv_next = s_axi_rvalid & ~s_axi_rready;
        rd_next = s_axi_rdata;
        rr_next = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_next = 1'b1;
            rr_next = 2'h0;
            case (s_axi_araddr)
                `CPID_ADDR_CTRL:   rd_next = 32'(cfg_reg);
                `CPID_ADDR_SMOOTH: rd_next = 32'(smooth_reg);
                `CPID_ADDR_TLIM:   rd_next = 32'(tlim_reg);
                `CPID_ADDR_INPW:   rd_next = 32'(inpw_reg);
                `CPID_ADDR_ERRTH:  rd_next = 32'(errth_reg);
                `CPID_ADDR_STATUS: rd_next = 32'(stat);
                `CPID_ADDR_DEV:    rd_next = 32'(dev_reg);  // Sign-extended
                default: begin
                    rd_next = 32'h0;
                    rr_next = 2'h2;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            awh_reg <= 1'b0;
            awa_reg <= 8'h00;
            wh_reg  <= 1'b0;
            wd_reg  <= 32'h0;
            ws_reg  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'h0;
            cfg_reg    <= `CPID_CTRL_RST | {4'h0, COUNT_DIR_RST, 3'h0};
            smooth_reg <= 11'h000;
            tlim_reg   <= `CPID_TLIM_RST;
            inpw_reg   <= '0;
            errth_reg  <= '1;
        end else begin
            awh_reg <= awh_next;
            awa_reg <= awa_next;
            wh_reg  <= wh_next;
            wd_reg  <= wd_next;
            ws_reg  <= ws_next;
            s_axi_bvalid <= bv_next;
            s_axi_bresp  <= br_next;
            s_axi_rvalid <= rv_next;
            s_axi_rdata  <= rd_next;
            s_axi_rresp  <= rr_next;
            cfg_reg    <= cfg_next;
            smooth_reg <= smooth_next;
            tlim_reg   <= tlim_next;
            inpw_reg   <= inpw_next;
            errth_reg  <= errth_next;
        end
    end

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    property p_fmt_legal; // see RULE1
        @(posedge clk_i) disable iff (!rstn_i) cfg_reg.pulse_format <= `CPID_FMT_MAX;
    endproperty
    a_fmt_legal: assert property (p_fmt_legal) else $error("bad format");
    property p_pair; // see RULE2
        @(posedge clk_i) disable iff (!rstn_i)
        (cfg_reg.pulse_format == `CPID_FMT_PAIR && a_rise && !b_rise)
            |-> dec_step && (dec_up == ~cfg_reg.count_dir);
    endproperty
    a_pair: assert property (p_pair) else $error("pair decode wrong");
    property p_sign; // see RULE3
        @(posedge clk_i) disable iff (!rstn_i)
        (cfg_reg.pulse_format == `CPID_FMT_SIGN && a_rise)
            |-> dec_step && (dec_up == (b_n ^ cfg_reg.count_dir));
    endproperty
    a_sign: assert property (p_sign) else $error("sign decode wrong");
    property p_quad; // see RULE4
        @(posedge clk_i) disable iff (!rstn_i)
        (cfg_reg.pulse_format == `CPID_FMT_QUAD && (ch_a ^ ch_b)) |-> dec_step;
    endproperty
    a_quad: assert property (p_quad) else $error("quad edge lost");
    property p_nofilt; // see RULE7
        @(posedge clk_i) disable iff (!rstn_i)
        (smooth_reg == 11'h000 && dec_step && pend_reg == '0 && !clear_now)
            |=> cmd_step_o && (cmd_fwd_o == $past(dec_up));
    endproperty
    a_nofilt: assert property (p_nofilt) else $error("unfiltered step lost");
    property p_tlim; // see RULE9
        @(posedge clk_i) disable iff (!rstn_i) tlim_reg <= `CPID_TLIM_MAX;
    endproperty
    a_tlim: assert property (p_tlim) else $error("limit out of range");
    property p_tl_dis; // see RULE15
        @(posedge clk_i) disable iff (!rstn_i)
        (cfg_reg.tl_in_dis || home_return_i) |=> !limit_en_o ##0
            current_limit_o == `CPID_NO_LIMIT;
    endproperty
    a_tl_dis: assert property (p_tl_dis) else $error("limit not ignored");
    property p_inp_off; // see RULE16
        @(posedge clk_i) disable iff (!rstn_i) !servo_on_i |=> !in_position_flag_o;
    endproperty
    a_inp_off: assert property (p_inp_off) else $error("in-position while off");
    property p_clear; // see RULE17
        @(posedge clk_i) disable iff (!rstn_i)
        clear_now |=> !torque_limited_flag_o && dev_reg == '0 && pend_reg == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear incomplete");
    property p_mon_off; // see RULE13
        @(posedge clk_i) disable iff (!rstn_i)
        (!cfg_reg.err_mon && !err_reg) |=> !err_reg;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("error without monitor");
endmodule : cpid_top

// ---- logic/cpid_params.svh ----
/*
 Constants of the command pulse input decoder: offsets, fields, resets, timing.
 Assumes a 20 MHz core clock and a 32-bit AXI4-Lite register port.
*/
// Behaviour
// RULE1: Format select 0..2, reset value 1
// RULE2: Format 2: first input forward, second reverse
// RULE3: Format 1: pulses on first, sign on second
// RULE4: Format 0: quadrature, four counts per cycle
// RULE5: Polarity selects active level and sign sense
// RULE6: Count direction bit inverts decoded direction
// RULE7: First-order smoothing 0..100 ms, travel kept
// RULE8: Settling after pulses stop about three tau
// RULE9: Torque limit percent 0..70, reset 70
// RULE10: Torque request clamps current to limit
// RULE11: Limited flag when current reaches limit
// RULE12: Stop-clear option clears on servo-off, alarm
// RULE13: Optional deviation error while torque limiting
// RULE14: Clear input enabled by option 0
// RULE15: Torque request input enabled by option 0
// RULE16: In-position when deviation within width, servo on
// RULE17: Clear on rising edge, drops limited flag
// RULE18: Torque request ignored in homing, forced stop
// RULE19: Host holds request while limited flag set
// RULE20: Deviation adds command, subtracts feedback
// RULE21: Inputs synchronised before edge detection
`ifndef CPID_PARAMS_SVH
`define CPID_PARAMS_SVH
// -----------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------
`define CPID_ADDR_CTRL   8'h00
`define CPID_ADDR_SMOOTH 8'h04
`define CPID_ADDR_TLIM   8'h08
`define CPID_ADDR_INPW   8'h0C
`define CPID_ADDR_ERRTH  8'h10
`define CPID_ADDR_STATUS 8'h14
`define CPID_ADDR_DEV    8'h18
// -----------------------------------------------------------
// Field values and resets
// -----------------------------------------------------------
`define CPID_FMT_QUAD    2'h0
`define CPID_FMT_SIGN    2'h1
`define CPID_FMT_PAIR    2'h2
`define CPID_FMT_MAX     2'h2
`define CPID_CTRL_RST    8'h11
`define CPID_SMOOTH_MAX  11'h3E8
`define CPID_TLIM_MAX    7'h46
`define CPID_TLIM_RST    7'h46
`define CPID_NO_LIMIT    7'h64
`define CPID_ERR_BIT     2
// -----------------------------------------------------------
// Timing: smoothing time unit is 0.1 ms
// -----------------------------------------------------------
`define CPID_CLK_NS      50
`define CPID_UNIT_NS     100000
`define CPID_UNIT_CYC    (`CPID_UNIT_NS / `CPID_CLK_NS)
`define CPID_SETTLE_MULT 3
`endif

// ---- logic/cpid_pkg.sv ----
/*
 Types of the command pulse input decoder.
 Assumes cpid_params.svh supplies the numeric constants.
*/
package cpid_pkg;
    // Control register layout, high bit first in the word
    typedef struct packed {
        logic       tl_in_dis;    // Torque request input disabled
        logic       clr_in_dis;   // Clear request input disabled
        logic       err_mon;      // Error monitor while limiting
        logic       stop_clear;   // Clear on servo-off or alarm
        logic       count_dir;    // Reverse decoded direction
        logic       polarity;     // Negative logic when set
        logic [1:0] pulse_format; // Decode format
    } cpid_cfg_type;

    // Status word layout
    typedef struct packed {
        logic limit_active;       // Torque limit in force
        logic dev_error;          // Sticky deviation error
        logic torque_limited;     // Limited flag
        logic in_position;        // In-position flag
    } cpid_stat_type;
endpackage : cpid_pkg

// ---- dv/cpid_host_model.sv ----
/* Host pulse generator model driving the two command pins.
   Assumes the decoder samples both pins on clk_i. */
`timescale 1ns/1ps
module cpid_host_model (
    input  wire logic clk_i,
    output logic      pa_o,  // First pin
    output logic      pb_o   // Second pin
);
    initial pa_o = 1'b0;
    initial pb_o = 1'b0;
    // Each level stands six edges
    task lv(input logic [1:0] ab);
        @(posedge clk_i);
        pa_o <= ab[1];
        pb_o <= ab[0];
        repeat (5) @(posedge clk_i);
    endtask : lv
    // One quadrature cycle, A leading B when fwd is set
    task quad(input logic fwd);
        lv({fwd, !fwd});
        lv(2'h3);
        lv({!fwd, fwd});
        lv(2'h0);
    endtask : quad
endmodule : cpid_host_model

// ---- dv/test_command_pulse_input_decoder.sv ----
/* Self-checking bench of the command pulse input decoder.
   Assumes cpid_top and cpid_host_model are compiled before it. */
`timescale 1ns/1ps
module test_command_pulse_input_decoder;
    logic clk_i = 0, rstn_i = 0, torque_limit_request_i = 0, deviation_clear_request_i = 0;
    logic servo_on_i = 1, alarm_i = 0, home_return_i = 0, forced_stop_i = 0;
    logic enc_step_i = 0, enc_fwd_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, pa, pb;
    logic cmd_step_o, cmd_fwd_o, limit_en_o, torque_limited_flag_o, in_position_flag_o;
    logic dev_error_o, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [6:0]  torque_current_i = 7'h1E, current_limit_o;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          n_errors = 0, compares = 0, cycles = 0;
    cpid_host_model u_host (.clk_i, .pa_o(pa), .pb_o(pb));
    cpid_top u_dut (.clk_i, .rstn_i, .forward_pulse_i(pa), .reverse_sign_i(pb),
        .torque_limit_request_i, .deviation_clear_request_i, .servo_on_i, .alarm_i,
        .home_return_i, .forced_stop_i, .enc_step_i, .enc_fwd_i, .torque_current_i,
        .cmd_step_o, .cmd_fwd_o, .limit_en_o, .current_limit_o, .torque_limited_flag_o,
        .in_position_flag_o, .dev_error_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    initial forever #25 clk_i = ~clk_i;
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            results;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Readies are sampled at the falling edge
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, da, dw;
        da = 0;
        dw = 0;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(da && dw)) begin
            @(negedge clk_i);
            ta = s_axi_awready;
            tw = s_axi_wready;
            @(posedge clk_i);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            da |= ta;
            dw |= tw;
        end
        do begin
            @(negedge clk_i);
            ta = s_axi_bvalid;
            @(posedge clk_i);
        end while (!ta);
        s_axi_bready <= 0;
    endtask : wr
    task rd(input logic [7:0] a);
        logic t;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(negedge clk_i);
            t = s_axi_arready;
            @(posedge clk_i);
        end while (!t);
        s_axi_arvalid <= 0;
        do begin
            @(negedge clk_i);
            t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_i);
        end while (!t);
        s_axi_rready <= 0;
    endtask : rd
    task dchk(input logic [31:0] e);
        repeat (12) @(posedge clk_i);
        rd(8'h18);
        chk(d, e);
    endtask : dchk
    // Pulse: levels lo, hi, lo again
    task pls(input logic [1:0] hi, input logic [1:0] lo);
        u_host.lv(lo);
        u_host.lv(hi);
        u_host.lv(lo);
    endtask : pls
    task clr;
        deviation_clear_request_i <= 1;
        repeat (6) @(posedge clk_i);
        deviation_clear_request_i <= 0;
    endtask : clr
    task results;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task t_regs;
        rd(8'h00);
        chk(d, 32'h11);
        wr(8'h08, 32'h47);
        rd(8'h08);
        chk(d, 32'h46);
        rd(8'h1C);
        chk(32'(r), 32'h2);
        $display("test regs done");
    endtask : t_regs
    task t_count;
        repeat (3) pls(2'h3, 2'h1);
        dchk(32'h3);
        pls(2'h2, 2'h0);
        dchk(32'h2);
        servo_on_i <= 0;
        dchk(32'h0);
        chk(32'(in_position_flag_o), 32'h0);
        servo_on_i <= 1;
        wr(8'h00, 32'h12);
        pls(2'h2, 2'h0);
        pls(2'h2, 2'h0);
        pls(2'h1, 2'h0);
        dchk(32'h1);
        enc_step_i <= 1;
        enc_fwd_i <= 1;
        @(posedge clk_i);
        enc_step_i <= 0;
        dchk(32'h0);
        wr(8'h00, 32'h1A);
        pls(2'h2, 2'h0);
        dchk(32'hFFFFFFFF);
        clr;
        dchk(32'h0);
        wr(8'h00, 32'h10);
        u_host.quad(1);
        dchk(32'h4);
        u_host.quad(0);
        dchk(32'h0);
        chk(32'(in_position_flag_o), 32'h1);
        u_host.lv(2'h2);
        wr(8'h00, 32'h15);
        clr;
        pls(2'h0, 2'h2);
        dchk(32'h1);
        wr(8'h00, 32'h75);
        clr;
        dchk(32'h1);
        wr(8'h04, 32'h1);
        pls(2'h0, 2'h2);
        dchk(32'h1);
        repeat (2000) @(posedge clk_i);
        dchk(32'h2);
        $display("test count done");
    endtask : t_count
    task t_torque;
        wr(8'h08, 32'h1E);
        wr(8'h10, 32'h0);
        torque_limit_request_i <= 1;
        repeat (12) @(posedge clk_i);
        chk(32'(current_limit_o), 32'h1E);
        chk(32'(torque_limited_flag_o), 32'h1);
        chk(32'(dev_error_o), 32'h1);
        home_return_i <= 1;
        repeat (4) @(posedge clk_i);
        chk(32'(limit_en_o), 32'h0);
        torque_limit_request_i <= 0;
        wr(8'h00, 32'h11);
        home_return_i <= 0;
        clr;
        wr(8'h00, 32'h91);
        torque_limit_request_i <= 1;
        repeat (12) @(posedge clk_i);
        chk(32'(limit_en_o), 32'h0);
        torque_limit_request_i <= 0;
        $display("test torque done");
    endtask : t_torque
    initial begin
        repeat (5) @(posedge clk_i);
        rstn_i <= 1;
        t_regs;
        t_count;
        t_torque;
        results;
    end
endmodule : test_command_pulse_input_decoder
